// ### src/lpws_pkg.sv
// Package of constants and types for the low-power wake sequencer.
// Notes on behaviour
// - Capture timers run in wait; a timer request ends wait.
// - Capture timers halt in stop and resume only after an interrupt pin, keypad or reset exit.
// - Timebase runs in wait; its register reads zero in wait or stop.
// - Timebase runs in stop only when the oscillator-in-stop bit is set.
// - A wait wake restarts the processor clock and loads that event's vector.
// - Reset pin low, watchdog timeout or supply trip resets and fetches the reset vector.
// - Falling edge on the interrupt pin wakes and loads its own vector.
// - Break request in emulation mode ends wait or stop with the break vector.
// - Clock generator request ends wait with its own vector.
// - Keypad request ends wait with the keypad vector.
// - Timer A gives overflow, channel 1 and channel 0 vectors.
// - Timer B gives overflow and channel 0 to 5 vectors.
// - Synchronous serial unit has separate transmit and receive vectors.
// - Async serial unit has transmit, receive and receive-error vectors.
// - Converter done and timebase rollover each end wait through own vectors.
// - Stop ends only on reset pin, interrupt pin, keypad, supply trip, break, rollover.
// - Keypad pin wakes on falling edge, or rising edge when its polarity bit is set.
// - Timebase running in stop wakes the part on every rollover.
// - Stop recovery holds system clocks off for 4096 crystal cycles.
// - Short-recovery bit cuts the hold to 32 crystal cycles.
// - Monitor on from reset; disable bits clear; trip range 3 V unless set.
// - After a supply trip, reset holds and pin driven low until rising level.
// - Wait or stop clears the interrupt mask; reset exit sets it.
package lpws_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_VECTOR = 4'h8;
  localparam logic [3:0] ADDR_TBCNT = 4'hc;
  localparam int CTRL_SHORT_REC = 0;
  localparam int CTRL_OSC_STOP = 1;
  localparam int CTRL_MON_PWR_DIS = 2;
  localparam int CTRL_MON_RST_DIS = 3;
  localparam int CTRL_MON_STOP_EN = 4;
  localparam int CTRL_TRIP_RANGE = 5;
  localparam int CTRL_TB_ENABLE = 6;
  localparam int CTRL_KBD_POL_LSB = 8;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Recovery counts in crystal cycles, crystal divider and timebase width
  // ----------------------------------------------------------------
  localparam int REC_LONG_CYC = 4096;
  localparam int REC_SHORT_CYC = 32;
  localparam int XTAL_DIV_DEF = 1;
  localparam int TB_WIDTH_DEF = 8;

  // ----------------------------------------------------------------
  // Vectors, index 0 has the lowest priority
  // ----------------------------------------------------------------
  localparam int NSRC = 21;
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_TABLE [NSRC] = '{
    16'hffcc, 16'hffce, 16'hffd0, 16'hffd2, 16'hffdc, 16'hffde, 16'hffe0,
    16'hffe2, 16'hffe4, 16'hffe6, 16'hffe8, 16'hffea, 16'hffec, 16'hffee,
    16'hfff0, 16'hfff2, 16'hfff4, 16'hfff6, 16'hfff8, 16'hfffa, 16'hfffc};
  // Break, interrupt pin, keypad and rollover may end stop.
  localparam logic [20:0] STOP_WAKE_MASK = 21'h180050;

  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_WAIT = 3'b001,
    ST_STOP = 3'b010,
    ST_RECOVER = 3'b011,
    ST_RESET = 3'b100
  } lpws_state_type;

  // Peripheral interrupt requests, already gated by each unit's enables.
  typedef struct packed {
    logic break_req;
    logic emulation;
    logic clkgen_irq;
    logic [2:0] timer_a;
    logic [6:0] timer_b;
    logic [1:0] spi;
    logic [2:0] async_serial_unit;
    logic adc_irq;
  } lpws_src_type;

endpackage

// ### src/lpws_top.sv
// Wake, stop recovery and supply monitor control for the low-power modes.
//
// Chosen here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
module lpws_top
  import lpws_pkg::*;
#(
  parameter int REC_LONG = REC_LONG_CYC,
  parameter int REC_SHORT = REC_SHORT_CYC,
  parameter int XTAL_DIV = XTAL_DIV_DEF,
  parameter int TB_WIDTH = TB_WIDTH_DEF
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic enter_wait,
  input wire logic enter_stop,
  input wire logic ext_rst_n,
  input wire logic watchdog_timeout,
  input wire logic supply_below_fall,
  input wire logic supply_above_rise,
  input wire logic irq_pin,
  input wire logic [7:0] keypad_pins,
  input wire lpws_src_type src,
  output logic cpu_clk_en,
  output logic bus_clk_en,
  output logic timer_run,
  output logic tb_run,
  output logic pc_load,
  output logic [15:0] pc_vector,
  output logic irq_mask,
  output logic sys_reset,
  output logic rst_pin_o,
  output logic rst_pin_oe,
  output logic monitor_enable,
  output logic trip_range_5v
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  lpws_state_type state, next_state;
  logic [15:0] ctrl, next_ctrl;
  logic ack, next_ack;
  logic [31:0] next_readdata;
  logic [7:0] xdiv, next_xdiv;
  logic xtal_tick;
  logic [TB_WIDTH-1:0] tb_cnt, next_tb_cnt;
  logic tb_roll, next_tb_roll;
  logic irq_prev, next_irq_prev;
  logic [7:0] kbd_prev, next_kbd_prev;
  logic [7:0] kbd_edge;
  logic irq_edge, kbd_any, brk;
  logic [20:0] wake_req;
  logic lvi_hold, next_lvi_hold;
  logic uv_flag, next_uv_flag;
  logic mon_active, lvi_trip, rst_src;
  logic next_pc_load, next_irq_mask;
  logic [15:0] next_pc_vector, pending, next_pending;
  logic frozen, next_frozen;
  logic from_stop, next_from_stop;
  logic [11:0] rec_cnt, next_rec_cnt, rec_load;
  logic in_sleep;

  // Highest set request wins; a later index has higher priority.
  function automatic logic [15:0] pick_vec(input logic [20:0] req);
    logic [15:0] v;
    v = VEC_TABLE[0];
    for (int i = 0; i < NSRC; i++) begin
      if (req[i]) begin
        v = VEC_TABLE[i];
      end
    end
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Crystal clock enable
  // ----------------------------------------------------------------
  // One clock only, so crystal cycles are a divided enable pulse.
  assign xtal_tick = (xdiv == 8'h00);

  always_comb begin
    next_xdiv = xtal_tick ? 8'(XTAL_DIV - 1) : xdiv - 8'h01;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      xdiv <= 8'h00;
    end else begin
      xdiv <= next_xdiv;
    end
  end

  // ----------------------------------------------------------------
  // Edge detection on interrupt and keypad pins
  // ----------------------------------------------------------------
  // Previous levels reset high so an idle-high pin gives no false edge.
  assign irq_edge = irq_prev & ~irq_pin;
  assign next_irq_prev = irq_pin;
  assign next_kbd_prev = keypad_pins;

  generate
    for (genvar k = 0; k < 8; k++) begin : g_kbd
      // Polarity bit picks the rising edge instead of the falling one.
      assign kbd_edge[k] = ctrl[CTRL_KBD_POL_LSB + k] ?
        (~kbd_prev[k] & keypad_pins[k]) : (kbd_prev[k] & ~keypad_pins[k]);
    end
  endgenerate

  assign kbd_any = |kbd_edge;
  assign brk = src.break_req & src.emulation;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      irq_prev <= 1'b1;
      kbd_prev <= 8'hff;
    end else begin
      irq_prev <= next_irq_prev;
      kbd_prev <= next_kbd_prev;
    end
  end

  // ----------------------------------------------------------------
  // Periodic timebase
  // ----------------------------------------------------------------
  // Runs in wait; in stop only with the oscillator kept alive.
  assign tb_run = (state == ST_STOP) ? ctrl[CTRL_OSC_STOP] : 1'b1;

  always_comb begin
    next_tb_cnt = tb_cnt;
    next_tb_roll = 1'b0;
    if (xtal_tick && tb_run && ctrl[CTRL_TB_ENABLE]) begin
      next_tb_cnt = tb_cnt + 1'b1;
      next_tb_roll = &tb_cnt;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tb_cnt <= '0;
      tb_roll <= 1'b0;
    end else begin
      tb_cnt <= next_tb_cnt;
      tb_roll <= next_tb_roll;
    end
  end

  // ----------------------------------------------------------------
  // Wake request vector in priority order
  // ----------------------------------------------------------------
  assign wake_req = {brk, irq_edge, src.clkgen_irq,
    src.timer_a[1], src.timer_a[2], src.timer_a[0],
    src.timer_b[1], src.timer_b[2], src.timer_b[0],
    src.spi[1], src.spi[0],
    src.async_serial_unit[2], src.async_serial_unit[1], src.async_serial_unit[0],
    kbd_any, src.adc_irq, tb_roll,
    src.timer_b[3], src.timer_b[4], src.timer_b[5], src.timer_b[6]};

  // ----------------------------------------------------------------
  // Supply monitor
  // ----------------------------------------------------------------
  // In stop the monitor needs its own enable bit to stay awake.
  assign mon_active = ~ctrl[CTRL_MON_PWR_DIS] &
    ((state != ST_STOP) | ctrl[CTRL_MON_STOP_EN]);
  assign lvi_trip = mon_active & ~ctrl[CTRL_MON_RST_DIS] & supply_below_fall;
  assign monitor_enable = mon_active;
  assign trip_range_5v = ctrl[CTRL_TRIP_RANGE];

  always_comb begin
    next_lvi_hold = lvi_hold;
    next_uv_flag = uv_flag;
    // Hysteresis: once tripped, only the rising level releases reset.
    if (lvi_trip) begin
      next_lvi_hold = 1'b1;
    end else if (supply_above_rise) begin
      next_lvi_hold = 1'b0;
    end
    if (mon_active && supply_below_fall) begin
      next_uv_flag = 1'b1;
    end else if (mon_active && supply_above_rise) begin
      next_uv_flag = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lvi_hold <= 1'b0;
      uv_flag <= 1'b0;
    end else begin
      lvi_hold <= next_lvi_hold;
      uv_flag <= next_uv_flag;
    end
  end

  // Watchdog has no clock in stop, so it cannot end stop.
  assign rst_src = ~ext_rst_n | lvi_trip | lvi_hold |
    (watchdog_timeout & (state != ST_STOP));
  assign sys_reset = rst_src | (state == ST_RESET);
  assign rst_pin_o = 1'b0;
  assign rst_pin_oe = lvi_hold;

  // ----------------------------------------------------------------
  // Mode sequencer
  // ----------------------------------------------------------------
  assign rec_load = ctrl[CTRL_SHORT_REC] ? 12'(REC_SHORT - 1) :
    12'(REC_LONG - 1);

  always_comb begin
    next_state = state;
    next_pc_load = 1'b0;
    next_pc_vector = pc_vector;
    next_irq_mask = irq_mask;
    next_frozen = frozen;
    next_from_stop = from_stop;
    next_rec_cnt = rec_cnt;
    next_pending = pending;
    if (rst_src) begin
      // Reset beats every interrupt raised in the same cycle.
      next_state = ST_RESET;
      next_irq_mask = 1'b1;
      next_frozen = 1'b0;
      if (state == ST_STOP || state == ST_RECOVER) begin
        next_from_stop = 1'b1;
      end
    end else begin
      case (state)
        ST_RUN: begin
          if (enter_stop) begin
            next_state = ST_STOP;
            next_irq_mask = 1'b0;
            next_frozen = 1'b1;
          end else if (enter_wait) begin
            next_state = ST_WAIT;
            next_irq_mask = 1'b0;
          end
        end
        ST_WAIT: begin
          if (|wake_req) begin
            next_state = ST_RUN;
            next_pc_load = 1'b1;
            next_pc_vector = pick_vec(wake_req);
          end
        end
        ST_STOP: begin
          if (|(wake_req & STOP_WAKE_MASK)) begin
            next_state = ST_RECOVER;
            next_pending = pick_vec(wake_req & STOP_WAKE_MASK);
            next_rec_cnt = rec_load;
            if (irq_edge || kbd_any) begin
              next_frozen = 1'b0;
            end
          end
        end
        ST_RECOVER: begin
          if (xtal_tick) begin
            if (rec_cnt == 12'h000) begin
              next_state = ST_RUN;
              next_pc_load = 1'b1;
              next_pc_vector = pending;
            end else begin
              next_rec_cnt = rec_cnt - 12'h001;
            end
          end
        end
        ST_RESET: begin
          next_from_stop = 1'b0;
          if (from_stop) begin
            next_state = ST_RECOVER;
            next_pending = VEC_RESET;
            next_rec_cnt = rec_load;
          end else begin
            next_state = ST_RUN;
            next_pc_load = 1'b1;
            next_pc_vector = VEC_RESET;
          end
        end
        default: begin
          next_state = ST_RESET;
        end
      endcase
    end
  end

  // Power-up starts in reset so the first fetch is the reset vector.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_RESET;
      pc_load <= 1'b0;
      pc_vector <= VEC_RESET;
      irq_mask <= 1'b1;
      frozen <= 1'b0;
      from_stop <= 1'b0;
      rec_cnt <= 12'h000;
      pending <= VEC_RESET;
    end else begin
      state <= next_state;
      pc_load <= next_pc_load;
      pc_vector <= next_pc_vector;
      irq_mask <= next_irq_mask;
      frozen <= next_frozen;
      from_stop <= next_from_stop;
      rec_cnt <= next_rec_cnt;
      pending <= next_pending;
    end
  end

  // System clocks are off in stop and during the recovery hold.
  assign cpu_clk_en = (state == ST_RUN);
  assign bus_clk_en = (state != ST_STOP) && (state != ST_RECOVER);
  assign timer_run = ~frozen && (state != ST_STOP) && (state != ST_RECOVER);
  assign in_sleep = (state == ST_WAIT) || (state == ST_STOP);

  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------
  // Every access takes two cycles: waitrequest drops on the second.
  assign waitrequest = (read | write) & ~ack;

  always_comb begin
    next_ack = (read | write) & ~ack;
    next_ctrl = ctrl;
    next_readdata = readdata;
    if (write && ack && address == ADDR_CTRL) begin
      next_ctrl = writedata[15:0];
    end
    if (read && !ack) begin
      case (address)
        ADDR_CTRL: next_readdata = {16'h0000, ctrl};
        ADDR_STATUS: next_readdata = {24'h000000, 1'b0, lvi_hold, frozen, irq_mask,
          state == ST_RECOVER, state == ST_STOP, state == ST_WAIT, uv_flag};
        ADDR_VECTOR: next_readdata = {16'h0000, pc_vector};
        // The timebase count is hidden from the processor while asleep.
        ADDR_TBCNT: next_readdata = in_sleep ? 32'h00000000 : 32'(tb_cnt);
        default: next_readdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ack <= 1'b0;
      ctrl <= CTRL_RESET;
      readdata <= 32'h00000000;
    end else begin
      ack <= next_ack;
      ctrl <= next_ctrl;
      readdata <= next_readdata;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  sequence s_stop_exit;
    (state == ST_STOP) ##1 (state == ST_RECOVER);
  endsequence

  sequence s_wait_wake;
    (state == ST_WAIT) && !rst_src && (|wake_req);
  endsequence

  a_wait_timers_run: assert property ((state == ST_WAIT && !frozen) |-> timer_run)
    else $error("Capture timers stopped in wait.");
  a_stop_timers_halt: assert property ((state == ST_STOP) |-> !timer_run)
    else $error("Capture timers ran in stop.");
  a_tb_read_blocked: assert property ((read && !ack && address == ADDR_TBCNT && in_sleep)
    |=> (readdata == 32'h00000000))
    else $error("Timebase count readable while asleep.");
  a_tb_stop_gate: assert property ((state == ST_STOP && !ctrl[CTRL_OSC_STOP]) |-> !tb_run)
    else $error("Timebase ran in stop without oscillator.");
  a_wait_wake_load: assert property (s_wait_wake |=> (pc_load && cpu_clk_en)
    ##1 !pc_load)
    else $error("Wait wake did not load the vector once.");
  a_reset_vector: assert property ((state == ST_RESET && !rst_src && !from_stop)
    |=> (pc_load && pc_vector == VEC_RESET))
    else $error("Reset exit did not fetch the reset vector.");
  a_irq_pin_vector: assert property ((state == ST_WAIT && !rst_src && irq_edge && !brk)
    |=> (pc_vector == 16'hfffa))
    else $error("Interrupt pin wake loaded a wrong vector.");
  a_stop_recover_hold: assert property (s_stop_exit |-> (!cpu_clk_en && !bus_clk_en) [*8])
    else $error("System clocks ran early in stop recovery.");
  a_lvi_pin_low: assert property ((lvi_hold && !supply_above_rise)
    |=> (rst_pin_oe && sys_reset))
    else $error("Supply reset released or pin not driven.");
  a_mask_on_entry: assert property ((state == ST_RUN && !rst_src && (enter_wait || enter_stop))
    |=> !irq_mask)
    else $error("Interrupt mask not cleared on entry.");
  a_reset_wins: assert property ((state == ST_WAIT && rst_src) |=> (state == ST_RESET && !pc_load))
    else $error("Interrupt beat a reset source.");

endmodule
`default_nettype wire

// ### dv/lpws_cpu_model.sv
// Behavioural model of the processor core that sits beside the wake sequencer.
`timescale 1ns/10ps
`default_nettype none
module lpws_cpu_model (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [1:0] sleep_req,
  input wire logic pc_load,
  input wire logic [15:0] pc_vector,
  output logic enter_wait,
  output logic enter_stop,
  output logic [15:0] fetched
);
  // ----------------------------------------------------------------
  // Sleep instructions and vector fetch
  // ----------------------------------------------------------------
  // A request held for one cycle becomes a one-cycle instruction pulse.
  // The fetch latch keeps the vector the way the core would take it.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      enter_wait <= 1'b0;
      enter_stop <= 1'b0;
      fetched <= 16'h0000;
    end else begin
      enter_wait <= sleep_req[0];
      enter_stop <= sleep_req[1];
      if (pc_load) begin
        fetched <= pc_vector;
      end
    end
  end
endmodule
`default_nettype wire

// ### dv/lpws_top_test.sv
// Self-checking bench for the low-power wake sequencer.
`timescale 1ns/10ps
`default_nettype none
module lpws_top_test;
  import lpws_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  // A short long-recovery count keeps the run brief; bounds derive from it.
  localparam int REC_N = 64;
  localparam int TIMEOUT_CYC = 20000;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, rd;
  logic waitrequest, enter_wait, enter_stop;
  logic [1:0] sleep_req = 2'b00;
  logic rst_drv_n = 1'b1;
  wire ext_rst_n;
  logic watchdog_timeout = 1'b0;
  logic supply_below_fall = 1'b0;
  logic supply_above_rise = 1'b1;
  logic irq_pin = 1'b1;
  logic [7:0] keypad_pins = 8'hff;
  lpws_src_type src = '0;
  logic cpu_clk_en, bus_clk_en, timer_run, tb_run, pc_load, irq_mask, sys_reset;
  logic rst_pin_o, rst_pin_oe, monitor_enable, trip_range_5v;
  logic [15:0] pc_vector, fetched;
  int failures = 0;
  int check_count = 0;
  int cyc = 0;
  int n;
  // Wake vector of each of the 17 low request bits of the packed source struct, bit 0 first.
  logic [15:0] vec_of_bit [17] = '{16'hffde, 16'hffe2, 16'hffe4, 16'hffe6, 16'hffe8, 16'hffea,
    16'hffec, 16'hfff0, 16'hffee, 16'hffd2, 16'hffd0, 16'hffce, 16'hffcc, 16'hfff2, 16'hfff6,
    16'hfff4, 16'hfff8};

  // The reset pin is pulled up; the sequencer may pull it low.
  assign ext_rst_n = rst_pin_oe ? rst_pin_o : rst_drv_n;

  lpws_top #(.REC_LONG(REC_N), .REC_SHORT(32), .XTAL_DIV(1), .TB_WIDTH(4)) lpws_top_inst (
    .sys_clk(sys_clk), .nrst(nrst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .enter_wait(enter_wait), .enter_stop(enter_stop), .ext_rst_n(ext_rst_n),
    .watchdog_timeout(watchdog_timeout), .supply_below_fall(supply_below_fall),
    .supply_above_rise(supply_above_rise), .irq_pin(irq_pin), .keypad_pins(keypad_pins),
    .src(src), .cpu_clk_en(cpu_clk_en), .bus_clk_en(bus_clk_en), .timer_run(timer_run),
    .tb_run(tb_run), .pc_load(pc_load), .pc_vector(pc_vector), .irq_mask(irq_mask),
    .sys_reset(sys_reset), .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe),
    .monitor_enable(monitor_enable), .trip_range_5v(trip_range_5v));

  lpws_cpu_model lpws_cpu_model_inst (
    .sys_clk(sys_clk), .nrst(nrst), .sleep_req(sleep_req), .pc_load(pc_load),
    .pc_vector(pc_vector), .enter_wait(enter_wait), .enter_stop(enter_stop), .fetched(fetched));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // The request stands until waitrequest is seen low at a rising edge; read data is taken at that edge.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= ~wr;
    do begin
      @(posedge sys_clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 50);
    if (k >= 50) failures++;
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  // Sends a sleep instruction and returns mid-cycle once the mode has settled.
  task automatic nap(input logic [1:0] kind);
    @(posedge sys_clk);
    sleep_req <= kind;
    @(posedge sys_clk);
    sleep_req <= 2'b00;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  // Waits for the vector load and checks its value and how long it took.
  task automatic wait_load(input logic [15:0] exp, input int lo, input int hi);
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (pc_load !== 1'b1 && n < 400);
    chk_word({16'h0, pc_vector}, {16'h0, exp});
    chk_bit(n >= lo && n <= hi, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------------------------------
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  // A hang is cut short well beyond the few hundred cycles the tests need.
  initial begin
    while (cyc < TIMEOUT_CYC) begin
      @(posedge sys_clk);
      cyc++;
    end
    failures++;
    give_verdict();
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    wait_load(16'hfffe, 1, 3);
    chk_bit(irq_mask, 1'b1);
    chk_bit(monitor_enable, 1'b1);
    chk_bit(trip_range_5v, 1'b0);
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk_word(rd, 32'h0);
    bus(1'b0, 4'h2, 32'h0);
    chk_word(rd, 32'h0);
    nap(2'b01);
    chk_bit(cpu_clk_en, 1'b0);
    chk_bit(timer_run & tb_run, 1'b1);
    bus(1'b0, ADDR_TBCNT, 32'h0);
    chk_word(rd, 32'h0);
    irq_pin <= 1'b0;
    wait_load(16'hfffa, 1, 4);
    chk_bit(irq_mask, 1'b0);
    @(posedge sys_clk);
    irq_pin <= 1'b1;
    for (int b = 0; b < 17; b++) begin
      nap(2'b01);
      @(posedge sys_clk);
      src <= lpws_src_type'(19'h1 << b);
      wait_load(vec_of_bit[b], 1, 4);
      @(posedge sys_clk);
      src <= '0;
    end
    nap(2'b01);
    @(posedge sys_clk);
    keypad_pins[3] <= 1'b0;
    wait_load(16'hffe0, 1, 4);
    @(posedge sys_clk);
    keypad_pins[3] <= 1'b1;
    // A break outside emulation must leave the part asleep.
    nap(2'b01);
    @(posedge sys_clk);
    src.break_req <= 1'b1;
    repeat (5) @(negedge sys_clk);
    chk_bit(cpu_clk_en, 1'b0);
    @(posedge sys_clk);
    src.emulation <= 1'b1;
    wait_load(16'hfffc, 1, 4);
    @(posedge sys_clk);
    src <= '0;
    // Every peripheral source and the interrupt pin at once together with a watchdog timeout.
    nap(2'b01);
    @(posedge sys_clk);
    src <= lpws_src_type'(19'h7ffff);
    watchdog_timeout <= 1'b1;
    irq_pin <= 1'b0;
    @(posedge sys_clk);
    watchdog_timeout <= 1'b0;
    wait_load(16'hfffe, 1, 8);
    chk_bit(irq_mask, 1'b1);
    @(posedge sys_clk);
    src <= '0;
    irq_pin <= 1'b1;
    // Stop with full recovery; timer requests are ignored while stopped.
    nap(2'b10);
    @(posedge sys_clk);
    src.timer_a <= 3'b001;
    repeat (5) @(negedge sys_clk);
    chk_bit(cpu_clk_en | bus_clk_en, 1'b0);
    chk_bit(timer_run | tb_run, 1'b0);
    @(posedge sys_clk);
    src <= '0;
    irq_pin <= 1'b0;
    wait_load(16'hfffa, REC_N, REC_N + 6);
    chk_bit(timer_run, 1'b1);
    @(posedge sys_clk);
    irq_pin <= 1'b1;
    // Short recovery and a rising keypad edge with its polarity bit set.
    bus(1'b1, ADDR_CTRL, 32'h0101);
    keypad_pins[0] <= 1'b0;
    nap(2'b10);
    @(posedge sys_clk);
    keypad_pins[0] <= 1'b1;
    wait_load(16'hffe0, 32, 38);
    // Timebase kept running in stop gives a periodic wake; timers stay halted.
    bus(1'b1, ADDR_CTRL, 32'h0043);
    nap(2'b10);
    chk_bit(tb_run, 1'b1);
    // The count is running here, so a leak through the read path would show.
    bus(1'b0, ADDR_TBCNT, 32'h0);
    chk_word(rd, 32'h0);
    wait_load(16'hffdc, 32, 56);
    chk_bit(timer_run, 1'b0);
    bus(1'b1, ADDR_CTRL, 32'h0001);
    nap(2'b10);
    @(posedge sys_clk);
    src <= lpws_src_type'(19'h60000);
    wait_load(16'hfffc, 32, 38);
    @(posedge sys_clk);
    src <= '0;
    nap(2'b10);
    @(posedge sys_clk);
    rst_drv_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_drv_n <= 1'b1;
    wait_load(16'hfffe, 32, 45);
    chk_bit(irq_mask, 1'b1);
    // Supply trip, hold between the levels, release above the rising level.
    bus(1'b1, ADDR_CTRL, 32'h0020);
    supply_above_rise <= 1'b0;
    supply_below_fall <= 1'b1;
    repeat (3) @(negedge sys_clk);
    chk_bit(trip_range_5v, 1'b1);
    chk_bit(sys_reset & rst_pin_oe & ~rst_pin_o, 1'b1);
    @(posedge sys_clk);
    supply_below_fall <= 1'b0;
    repeat (5) @(negedge sys_clk);
    chk_bit(sys_reset & rst_pin_oe, 1'b1);
    @(posedge sys_clk);
    supply_above_rise <= 1'b1;
    wait_load(16'hfffe, 1, 8);
    repeat (3) @(negedge sys_clk);
    chk_bit(rst_pin_oe, 1'b0);
    bus(1'b1, ADDR_CTRL, 32'h0008);
    supply_above_rise <= 1'b0;
    supply_below_fall <= 1'b1;
    repeat (3) @(negedge sys_clk);
    chk_bit(sys_reset, 1'b0);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk_bit(rd[0], 1'b1);
    supply_below_fall <= 1'b0;
    supply_above_rise <= 1'b1;
    bus(1'b1, ADDR_CTRL, 32'h0004);
    @(negedge sys_clk);
    chk_bit(monitor_enable, 1'b0);
    chk_word({16'h0, fetched}, 32'hfffe);
    bus(1'b0, ADDR_VECTOR, 32'h0);
    chk_word(rd, 32'h0000fffe);
    give_verdict();
  end
endmodule
`default_nettype wire
